/* rtl/irq_pkg.sv */
// shared constants and types of the interrupt-source block
package irq_pkg;

	// -----------------------------------------------------------------
	// register byte offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] addr_reset_cause = 8'h00;
	localparam logic [7:0] addr_main_ctrl = 8'h04;
	localparam logic [7:0] addr_second_ctrl = 8'h08;
	localparam logic [7:0] addr_third_ctrl = 8'h0c;
	localparam logic [7:0] addr_config = 8'h10;
	localparam logic [7:0] addr_irq_status = 8'h14;
	localparam logic [7:0] addr_irq_mask = 8'h18;

	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int rc_prio_en = 7;
	localparam int rc_sw_brownout = 6;
	localparam int rc_unused = 5;
	localparam int rc_reset_instr = 4;
	localparam int rc_wdt_timeout = 3;
	localparam int rc_powerdown = 2;
	localparam int mc_global = 7;
	localparam int mc_low_enable = 6;
	localparam int mc_timer0_en = 5;
	localparam int mc_ext0_en = 4;
	localparam int mc_portb_en = 3;
	localparam int mc_timer0_flag = 2;
	localparam int mc_ext0_flag = 1;
	localparam int mc_portb_flag = 0;
	localparam int sc_edge0 = 6;
	localparam int sc_edge1 = 5;
	localparam int sc_edge2 = 4;
	localparam int sc_timer0_prio = 2;
	localparam int sc_portb_prio = 0;
	localparam int tc_ext2_prio = 7;
	localparam int tc_ext1_prio = 6;
	localparam int tc_ext2_en = 4;
	localparam int tc_ext1_en = 3;
	localparam int tc_ext2_flag = 1;
	localparam int tc_ext1_flag = 0;
	localparam int cf_timer0_16bit = 0;

	// -----------------------------------------------------------------
	// reset values and sizes
	// -----------------------------------------------------------------
	localparam logic [7:0] reset_cause_init = 8'h1c;
	localparam logic [7:0] main_ctrl_init = 8'h00;
	localparam logic [7:0] second_ctrl_init = 8'hf5;
	localparam logic [7:0] third_ctrl_init = 8'hc0;
	localparam int pin_count = 7;
	localparam int pc_width = 21;
	localparam int stack_depth = 32;
	localparam int stack_ptr_width = 5;
	localparam int event_count = 6;

	typedef struct packed {
		logic [7:0] working;
		logic [7:0] status;
		logic [7:0] bank;
	} core_context_type;

	typedef struct packed {
		logic reset_instr;
		logic wdt_timeout;
		logic sleep_entry;
	} cause_events_type;

endpackage

/* rtl/pin_edge_sync.sv */
// two-stage synchroniser and edge detector for the interrupt pins
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [irq_pkg::pin_count-1:0] pins,
	output logic [irq_pkg::pin_count-1:0] rise,
	output logic [irq_pkg::pin_count-1:0] fall
);
	import irq_pkg::*;

	typedef struct packed {
		logic [pin_count-1:0] meta;
		logic [pin_count-1:0] stable;
		logic [pin_count-1:0] prev;
		logic [pin_count-1:0] rise;
		logic [pin_count-1:0] fall;
		logic [2:0] armed;
	} sync_state_type;

	sync_state_type s, next_s;

	always_comb begin
		next_s = s;
		next_s.meta = pins;
		next_s.stable = s.meta;
		next_s.prev = s.stable;
		next_s.armed = {s.armed[1:0], 1'b1};
		// only the second stage feeds the comparators; edges stay masked until
		// prev holds a real pin level, so a pin high through reset is no edge
		for (int i = 0; i < pin_count; i++) begin
			next_s.rise[i] = s.armed[2] & s.stable[i] & ~s.prev[i];
			next_s.fall[i] = s.armed[2] & ~s.stable[i] & s.prev[i];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign rise = s.rise;
	assign fall = s.fall;
endmodule
`default_nettype wire

/* rtl/return_stack.sv */
// return address stack with a registered top-of-stack output
`timescale 1ns/1ps
`default_nettype none
module return_stack (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic push,
	input wire logic pop,
	input wire logic [irq_pkg::pc_width-1:0] push_pc,
	output logic [irq_pkg::pc_width-1:0] top_pc
);
	import irq_pkg::*;

	typedef struct packed {
		logic [stack_depth-1:0][pc_width-1:0] mem;
		logic [stack_ptr_width-1:0] ptr;
		logic [pc_width-1:0] top;
	} stack_state_type;

	stack_state_type s, next_s;

	always_comb begin
		next_s = s;
		// push wins when both arrive; the pointer wraps on overflow
		if (push) begin
			next_s.mem[s.ptr] = push_pc;
			next_s.ptr = s.ptr + 5'h01;
			next_s.top = push_pc;
		end else if (pop) begin
			next_s.ptr = s.ptr - 5'h01;
			next_s.top = s.mem[s.ptr - 5'h02];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign top_pc = s.top;
endmodule
`default_nettype wire

/* rtl/irq_sources.sv */
// interrupt sources, priority steering and context saving of the core
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module irq_sources (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [2:0] ext_pin,
	input wire logic [3:0] portb_upper,
	input wire logic [15:0] timer0_value,
	input wire irq_pkg::cause_events_type cause_events,
	input wire logic core_sleeping,
	input wire logic core_irq_entry,
	input wire logic core_return,
	input wire logic [irq_pkg::pc_width-1:0] core_pc,
	input wire irq_pkg::core_context_type core_context,
	output logic irq_high,
	output logic irq_low,
	output logic wake_request,
	output irq_pkg::core_context_type fast_shadow,
	output logic [irq_pkg::pc_width-1:0] stack_top,
	output logic irq
);
	import irq_pkg::*;

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] reset_cause;
		logic [7:0] main_ctrl;
		logic [7:0] second_ctrl;
		logic [7:0] third_ctrl;
		logic [7:0] config_reg;
		logic [event_count-1:0] status;
		logic [event_count-1:0] mask;
		logic [15:0] timer_prev;
		logic ack;
		logic [31:0] rdata;
		logic irq_high;
		logic irq_low;
		logic wake;
		logic irq;
		core_context_type shadow;
	} main_state_type;

	main_state_type s, next_s;

	logic [pin_count-1:0] pin_rise;
	logic [pin_count-1:0] pin_fall;
	logic [2:0] ext_edge;
	logic portb_change;
	logic timer_wrap;
	logic ext0_req;
	logic ext1_req;
	logic ext2_req;
	logic timer_req;
	logic portb_req;
	logic any_req;
	logic high_req;
	logic low_req;
	logic ext_pending;

	logic access;
	logic do_write;
	logic do_read;
	logic wr_reset_cause;
	logic wr_main;
	logic wr_second;
	logic wr_third;
	logic wr_config;
	logic wr_mask;
	logic [7:0] wbyte;
	logic [7:0] read_value;

	logic [event_count-1:0] new_events;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] target);
		hit = adr == target;
	endfunction

	// the edge select bit picks which detector output counts for a pin
	function automatic logic edge_pick(input logic sel, input logic up, input logic down);
		edge_pick = sel ? up : down;
	endfunction

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	pin_edge_sync u_sync (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.pins({portb_upper, ext_pin}),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	return_stack u_stack (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.push(core_irq_entry),
		.pop(core_return),
		.push_pc(core_pc),
		.top_pc(stack_top)
	);

	// -----------------------------------------------------------------
	// event detection
	// -----------------------------------------------------------------
	always_comb begin
		ext_edge[0] = edge_pick(s.second_ctrl[sc_edge0], pin_rise[0], pin_fall[0]);
		ext_edge[1] = edge_pick(s.second_ctrl[sc_edge1], pin_rise[1], pin_fall[1]);
		ext_edge[2] = edge_pick(s.second_ctrl[sc_edge2], pin_rise[2], pin_fall[2]);
		portb_change = |(pin_rise[6:3] | pin_fall[6:3]);
		if (s.config_reg[cf_timer0_16bit]) begin
			timer_wrap = s.timer_prev == 16'hffff && timer0_value == 16'h0000;
		end else begin
			timer_wrap = s.timer_prev[7:0] == 8'hff && timer0_value[7:0] == 8'h00;
		end
	end

	// -----------------------------------------------------------------
	// requests and priority steering
	// -----------------------------------------------------------------
	always_comb begin
		// a source asks only with flag and enable both set
		ext0_req = s.main_ctrl[mc_ext0_flag] & s.main_ctrl[mc_ext0_en];
		ext1_req = s.third_ctrl[tc_ext1_flag] & s.third_ctrl[tc_ext1_en];
		ext2_req = s.third_ctrl[tc_ext2_flag] & s.third_ctrl[tc_ext2_en];
		timer_req = s.main_ctrl[mc_timer0_flag] & s.main_ctrl[mc_timer0_en];
		portb_req = s.main_ctrl[mc_portb_flag] & s.main_ctrl[mc_portb_en];
		any_req = ext0_req | ext1_req | ext2_req | timer_req | portb_req;
		ext_pending = ext0_req | ext1_req | ext2_req;
		// pin 0 has no priority bit and is always high
		high_req = ext0_req
			| (ext1_req & s.third_ctrl[tc_ext1_prio])
			| (ext2_req & s.third_ctrl[tc_ext2_prio])
			| (timer_req & s.second_ctrl[sc_timer0_prio])
			| (portb_req & s.second_ctrl[sc_portb_prio]);
		low_req = any_req & ~high_req;
		if (s.reset_cause[rc_prio_en]) begin
			// low level needs both the global and the low-level enable
			high_req = high_req & s.main_ctrl[mc_global];
			low_req = low_req & s.main_ctrl[mc_global] & s.main_ctrl[mc_low_enable];
		end else begin
			// compatibility: one level, priority bits ignored
			high_req = any_req & s.main_ctrl[mc_global];
			low_req = 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// register bus decode
	// -----------------------------------------------------------------
	always_comb begin
		access = wb_cyc_i & wb_stb_i & ~s.ack;
		do_write = access & wb_we_i & wb_sel_i[0];
		do_read = access & ~wb_we_i;
		wbyte = wb_dat_i[7:0];
		new_events = {core_sleeping & ext_pending, portb_change, timer_wrap, ext_edge};
	end

	// -----------------------------------------------------------------
	// write strobes
	// -----------------------------------------------------------------
	// a write with sel[0] low is still acked but changes nothing
	always_comb begin
		wr_reset_cause = do_write & hit(wb_adr_i, addr_reset_cause);
		wr_main = do_write & hit(wb_adr_i, addr_main_ctrl);
		wr_second = do_write & hit(wb_adr_i, addr_second_ctrl);
		wr_third = do_write & hit(wb_adr_i, addr_third_ctrl);
		wr_config = do_write & hit(wb_adr_i, addr_config);
		wr_mask = do_write & hit(wb_adr_i, addr_irq_mask);
	end

	// -----------------------------------------------------------------
	// read multiplexer
	// -----------------------------------------------------------------
	// unmapped offsets read zero, so probing the map is harmless
	always_comb begin
		read_value = 8'h00;
		case (wb_adr_i)
			addr_reset_cause: begin
				read_value = s.reset_cause;
			end
			addr_main_ctrl: begin
				read_value = s.main_ctrl;
			end
			addr_second_ctrl: begin
				read_value = s.second_ctrl;
			end
			addr_third_ctrl: begin
				read_value = s.third_ctrl;
			end
			addr_config: begin
				read_value = s.config_reg;
			end
			addr_irq_status: begin
				read_value = 8'(s.status);
			end
			addr_irq_mask: begin
				read_value = 8'(s.mask);
			end
			default: begin
				read_value = 8'h00;
			end
		endcase
	end

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		next_s = s;
		// the last count is kept one cycle so a wrap is seen by both its ends
		next_s.timer_prev = timer0_value;
		next_s.ack = access;
		next_s.rdata = 32'h0000_0000;

		if (wr_reset_cause) begin
			// of the flags that hardware owns, only rc_reset_instr is writable by software
			next_s.reset_cause[rc_prio_en] = wbyte[rc_prio_en];
			next_s.reset_cause[rc_sw_brownout] = wbyte[rc_sw_brownout];
			next_s.reset_cause[rc_reset_instr] = wbyte[rc_reset_instr];
			next_s.reset_cause[1:0] = wbyte[1:0];
		end
		if (wr_main) begin
			next_s.main_ctrl = wbyte;
		end
		if (wr_second) begin
			next_s.second_ctrl = wbyte;
		end
		if (wr_third) begin
			next_s.third_ctrl = wbyte;
		end
		if (wr_config) begin
			next_s.config_reg = {7'h00, wbyte[cf_timer0_16bit]};
		end
		if (wr_mask) begin
			next_s.mask = wbyte[event_count-1:0];
		end

		if (do_read) begin
			next_s.rdata = {24'h00_0000, read_value};
		end
		// a status read clears what it reported; events below still land
		if (do_read && hit(wb_adr_i, addr_irq_status)) begin
			next_s.status = '0;
		end

		// reset-cause flags fall on their events
		if (cause_events.reset_instr) begin
			next_s.reset_cause[rc_reset_instr] = 1'b0;
		end
		if (cause_events.wdt_timeout) begin
			next_s.reset_cause[rc_wdt_timeout] = 1'b0;
		end
		if (cause_events.sleep_entry) begin
			next_s.reset_cause[rc_powerdown] = 1'b0;
		end
		next_s.reset_cause[rc_unused] = 1'b0;

		// events set flags whatever the enables, after any software clear;
		// only software clears them again, so a stale flag re-enters at once
		if (ext_edge[0]) begin
			next_s.main_ctrl[mc_ext0_flag] = 1'b1;
		end
		if (ext_edge[1]) begin
			next_s.third_ctrl[tc_ext1_flag] = 1'b1;
		end
		if (ext_edge[2]) begin
			next_s.third_ctrl[tc_ext2_flag] = 1'b1;
		end
		if (timer_wrap) begin
			next_s.main_ctrl[mc_timer0_flag] = 1'b1;
		end
		if (portb_change) begin
			next_s.main_ctrl[mc_portb_flag] = 1'b1;
		end
		next_s.status = next_s.status | new_events;

		// wake needs only sleep and an enabled pending pin; the vector also needs global
		next_s.wake = core_sleeping & ext_pending;
		next_s.irq_high = high_req;
		next_s.irq_low = low_req;
		next_s.irq = |(s.status & s.mask);

		if (core_irq_entry) begin
			next_s.shadow = core_context;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
			s.reset_cause <= reset_cause_init;
			s.main_ctrl <= main_ctrl_init;
			s.second_ctrl <= second_ctrl_init;
			s.third_ctrl <= third_ctrl_init;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign wb_dat_o = s.rdata;
	assign wb_ack_o = s.ack;
	assign irq_high = s.irq_high;
	assign irq_low = s.irq_low;
	assign wake_request = s.wake;
	assign fast_shadow = s.shadow;
	assign irq = s.irq;
endmodule
`default_nettype wire

/* verif/irq_sources_properties.sv */
// assertions on the ports of the interrupt-source block
`timescale 1ns/1ps
`default_nettype none
module irq_sources_check (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic core_sleeping,
	input wire logic core_irq_entry,
	input wire logic core_return,
	input wire logic [irq_pkg::pc_width-1:0] core_pc,
	input wire irq_pkg::core_context_type core_context,
	input wire logic wake_request,
	input wire irq_pkg::core_context_type fast_shadow,
	input wire logic [irq_pkg::pc_width-1:0] stack_top
);
	import irq_pkg::*;
	// ----------
	// sequences
	// ----------
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_take;
		ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_answer;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence s_entry;
		ce && core_irq_entry;
	endsequence
	// ----------
	// properties
	// ----------
	a_ack_one_cycle: assert property (s_take |=> s_answer)
		else $error("bus request not answered for exactly one cycle");
	a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	a_unused_bit_zero: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i == addr_reset_cause |-> !wb_dat_o[rc_unused])
		else $error("unused reset cause bit reads one");
	a_wake_needs_sleep: assert property ($rose(wake_request) |-> $past(core_sleeping))
		else $error("wake raised while core awake");
	a_shadow_capture: assert property (
		s_entry |=> fast_shadow == $past(core_context))
		else $error("shadow missed the context");
	a_stack_push: assert property (s_entry |=> stack_top == $past(core_pc))
		else $error("stack top missed the return address");
	a_shadow_holds: assert property (!(ce && core_irq_entry) |=> $stable(fast_shadow))
		else $error("shadow changed without entry");
	a_stack_holds: assert property (
		!(ce && (core_irq_entry || core_return)) |=> $stable(stack_top))
		else $error("stack top changed without push or pop");
endmodule
bind irq_sources irq_sources_check u_irq_sources_check (.clk, .reset, .ce, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .core_sleeping, .core_irq_entry,
	.core_return, .core_pc, .core_context, .wake_request, .fast_shadow, .stack_top);
`default_nettype wire

/* verif/core_model.sv */
// processor core stand-in: enters on a request, returns once it is gone
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic clk,
	input wire logic irq_high,
	input wire logic irq_low,
	output logic entry,
	output logic ret,
	output logic [irq_pkg::pc_width-1:0] pc,
	output irq_pkg::core_context_type ctx
);
	import irq_pkg::*;
	logic busy;
	core_context_type saved;
	initial begin
		entry = 1'b0;
		ret = 1'b0;
		busy = 1'b0;
		pc = '0;
		ctx = 24'h102030;
		saved = 24'h000000;
	end
	always @(posedge clk) begin
		entry <= 1'b0;
		ret <= 1'b0;
		if (!busy && (irq_high || irq_low)) begin
			entry <= 1'b1;
			busy <= 1'b1;
			pc <= pc + 21'h000004;
			saved <= ctx;
			ctx <= ctx + 24'h010307;
		end else if (busy && !irq_high && !irq_low) begin
			// no fast return: the routine puts back its own copy
			ret <= 1'b1;
			busy <= 1'b0;
			ctx <= saved;
		end
	end
endmodule
`default_nettype wire

/* verif/tb_irq_sources.sv */
// self-checking bench of the interrupt-source block
`timescale 1ns/1ps
`default_nettype none
module tb_irq_sources;
	import irq_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [2:0] pins = 3'h0;
	logic [3:0] pb = 4'h0;
	logic [15:0] tmr = 16'h0000;
	logic sleeping = 1'b0;
	logic ce = 1'b1;
	cause_events_type cev = '0;
	logic [31:0] rdat;
	logic ack, entry, ret, ih, il, wake, irq;
	logic [pc_width-1:0] pc, top;
	core_context_type ctx, shadow;
	int failures = 0;
	int checked = 0;
	always #5 clk = ~clk;
	irq_sources u_irq_sources (.clk, .reset, .ce, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ext_pin(pins), .portb_upper(pb), .timer0_value(tmr),
		.cause_events(cev), .core_sleeping(sleeping),
		.core_irq_entry(entry), .core_return(ret), .core_pc(pc), .core_context(ctx),
		.irq_high(ih), .irq_low(il), .wake_request(wake), .fast_shadow(shadow),
		.stack_top(top), .irq(irq));
	core_model u_core_model (.clk, .irq_high(ih), .irq_low(il), .entry, .ret, .pc, .ctx);
	// ----------
	// helpers
	// ----------
	function automatic logic [7:0] flag_reg(input int i);
		return i == 0 ? addr_main_ctrl : addr_third_ctrl;
	endfunction
	function automatic int flag_bit(input int i);
		return i == 0 ? mc_ext0_flag : i - 1;
	endfunction
	function automatic logic [7:0] edge_sel(input logic x);
		return x ? 8'h75 : 8'h05;
	endfunction
	task automatic report_and_stop;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (ack !== 1'b1) begin
			failures++;
			report_and_stop();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		check(q, {24'h0, e});
	endtask
	task automatic bit_is(input logic [7:0] a, input int b, input logic x);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		check(32'(q[b]), 32'(x));
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic levels(input logic [1:0] e);
		tick(2);
		check(32'({ih, il}), 32'(e));
	endtask
	task automatic pulse(input int i);
		pins[i] <= 1'b0;
		tick(6);
		pins[i] <= 1'b1;
		tick(6);
	endtask
	// ----------
	// scenarios
	// ----------
	initial begin
		logic [31:0] q;
		logic [7:0] h;
		void'($urandom(32'h842323df));
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(addr_reset_cause, reset_cause_init);
		rd(addr_main_ctrl, main_ctrl_init);
		rd(addr_second_ctrl, second_ctrl_init);
		rd(addr_third_ctrl, third_ctrl_init);
		rd(8'h40, 8'h00);
		wr(addr_reset_cause, 8'hff);
		rd(addr_reset_cause, 8'hdf);
		// cause events drop the three hardware-owned flags
		cev <= '1;
		@(posedge clk);
		cev <= '0;
		rd(addr_reset_cause, 8'hc3);
		for (int i = 0; i < 3; i++) begin
			for (int e = 0; e < 2; e++) begin
				wr(addr_second_ctrl, edge_sel(e[0]));
				pins[i] <= e[0];
				tick(6);
				wr(addr_main_ctrl, 8'h00);
				wr(addr_third_ctrl, 8'hc0);
				pins[i] <= !e[0];
				tick(6);
				bit_is(flag_reg(i), flag_bit(i), 1'b0);
				pins[i] <= e[0];
				tick(6);
				bit_is(flag_reg(i), flag_bit(i), 1'b1);
			end
		end
		wr(addr_main_ctrl, 8'h00);
		wr(addr_third_ctrl, 8'h08);
		wr(addr_main_ctrl, 8'hc0);
		pulse(1);
		levels(2'b01);
		wr(addr_third_ctrl, 8'h49);
		levels(2'b10);
		wr(addr_reset_cause, 8'h5f);
		wr(addr_third_ctrl, 8'h09);
		levels(2'b10);
		wr(addr_reset_cause, 8'hdf);
		wr(addr_third_ctrl, 8'h00);
		wr(addr_main_ctrl, 8'hd0);
		pulse(0);
		levels(2'b10);
		check(32'(top), 32'(pc));
		check(32'(shadow), 32'(ctx));
		sleeping <= 1'b1;
		tick(2);
		check(32'(wake), 32'h1);
		wr(addr_main_ctrl, 8'h02);
		tick(2);
		check(32'(wake), 32'h0);
		sleeping <= 1'b0;
		wr(addr_main_ctrl, 8'h00);
		wr(addr_irq_mask, 8'h00);
		bus(1'b0, addr_irq_status, 8'h00, q);
		h = 8'($urandom_range(254));
		// with ce low the block is frozen, so this wrap must pass unseen
		ce <= 1'b0;
		tmr <= {h, 8'hff};
		tick(2);
		tmr <= {h + 8'h01, 8'h00};
		tick(3);
		ce <= 1'b1;
		tick(2);
		bit_is(addr_main_ctrl, mc_timer0_flag, 1'b0);
		tmr <= {h, 8'hff};
		tick(2);
		tmr <= {h + 8'h01, 8'h00};
		tick(3);
		bit_is(addr_main_ctrl, mc_timer0_flag, 1'b1);
		check(32'(irq), 32'h0);
		wr(addr_irq_mask, 8'h08);
		tick(2);
		check(32'(irq), 32'h1);
		rd(addr_irq_status, 8'h08);
		tick(1);
		check(32'(irq), 32'h0);
		wr(addr_config, 8'h01);
		wr(addr_main_ctrl, 8'h00);
		tmr <= {h, 8'hff};
		tick(2);
		tmr <= {h + 8'h01, 8'h00};
		tick(3);
		bit_is(addr_main_ctrl, mc_timer0_flag, 1'b0);
		tmr <= 16'hffff;
		tick(2);
		tmr <= 16'h0000;
		tick(3);
		bit_is(addr_main_ctrl, mc_timer0_flag, 1'b1);
		wr(addr_second_ctrl, 8'h71);
		wr(addr_main_ctrl, 8'he4);
		levels(2'b01);
		wr(addr_second_ctrl, 8'h75);
		levels(2'b10);
		wr(addr_main_ctrl, 8'hc4);
		levels(2'b00);
		wr(addr_main_ctrl, 8'h00);
		pb <= pb ^ 4'(1 << $urandom_range(3));
		tick(6);
		bit_is(addr_main_ctrl, mc_portb_flag, 1'b1);
		wr(addr_second_ctrl, 8'h74);
		wr(addr_main_ctrl, 8'hc9);
		levels(2'b01);
		wr(addr_second_ctrl, 8'h75);
		levels(2'b10);
		report_and_stop();
	end
endmodule
`default_nettype wire
